// ---- bench/remote_serial_end.sv ----
// far-end serial device: drives the receive line, samples the send line
`timescale 1ns/10ps
module remote_serial_end (
   input wire logic core_clk,
   input wire logic serial_out_pin,
   output logic serial_in_pin
);
   initial serial_in_pin = 1'b1;

   // one bit time is 16 clocks with the divisor at zero
   task automatic bit_out(input logic b);
      begin
         @(negedge core_clk);
         serial_in_pin = b;
         repeat (15) @(negedge core_clk);
      end
   endtask : bit_out

   task automatic send(input logic [7:0] d, input int n, input int p,
         input logic pb);
      begin
         bit_out(1'b0);
         for (int i = 0; i < n; i++) bit_out(d[i]);
         if (p != 0) bit_out(pb);
         bit_out(1'b1);
      end
   endtask : send

   // samples mid-bit from the start edge; bits not sampled stay high
   task automatic recv(input int len, output logic [11:0] f);
      begin
         f = 12'hfff;
         wait (serial_out_pin === 1'b0);
         repeat (8) @(negedge core_clk);
         for (int i = 0; i < len; i++) begin
            f[i] = serial_out_pin;
            repeat (16) @(negedge core_clk);
         end
      end
   endtask : recv
endmodule : remote_serial_end

// ---- bench/tb_uart_line_format_datapath.sv ----
// self-checking bench for the serial line datapath
`timescale 1ns/10ps
`include "uart_params.svh"
`define CHK(a, b) \
   num_checks++; \
   if ((a) !== (b)) begin \
      miscompares++; \
      $display("BAD t=%0t got %h exp %h", $time, a, b); \
   end
module tb_uart_line_format_datapath;
   logic core_clk, rst, serial_in_pin, serial_out_pin;
   logic rts_n, dtr_n, cts_n, dsr_n, irq;
   uart_pkg::reg_req_t reg_req;
   logic [7:0] reg_rdata;
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;

   uart_line_format_datapath i_dut (.core_clk(core_clk), .rst(rst),
      .reg_req(reg_req), .reg_rdata(reg_rdata),
      .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
      .rts_n(rts_n), .dtr_n(dtr_n), .cts_n(cts_n), .dsr_n(dsr_n),
      .irq(irq));
   remote_serial_end i_far (.core_clk(core_clk),
      .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin));

   task automatic finish_test();
      begin
         $display("checks %0d mismatches %0d", num_checks, miscompares);
         if (miscompares == 0 && num_checks > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask : finish_test

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      begin
         @(negedge core_clk);
         reg_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
         @(negedge core_clk);
         reg_req.wr = 1'b0;
      end
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      begin
         @(negedge core_clk);
         reg_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
         @(negedge core_clk);
         reg_req.rd = 1'b0;
         d = reg_rdata;
      end
   endtask : rd

   // polls line status until the given bit is set
   task automatic wait_bit(input int b);
      logic [7:0] d;
      begin
         d = 8'h00;
         for (int i = 0; i < 400 && d[b] !== 1'b1; i++)
            rd(`ADDR_LINE_STATUS, d);
         `CHK(d[b], 1'b1)
      end
   endtask : wait_bit

   task automatic t_regs();
      logic [7:0] d;
      begin
         rd(`ADDR_LINE_FORMAT, d);
         `CHK(d, `REG_RESET)
         wr(`ADDR_LINE_FORMAT, 8'h9b);
         rd(`ADDR_LINE_FORMAT, d);
         `CHK(d, 8'h9b)
         rd(`ADDR_TX_HOLD_WRITE, d);
         `CHK(d, 8'h00)
         rd(16'hffac, d);
         `CHK(d, 8'h00)
         wr(`ADDR_RX_FIFO_READ, 8'h5a);
         rd(`ADDR_LINE_STATUS, d);
         `CHK(d[0], 1'b0)
      end
   endtask : t_regs

   task automatic t_tx_formats();
      logic [7:0] line_format_ctrl [6] = '{8'h00, 8'h01, 8'h0a, 8'h1b, 8'h2b, 8'h3b};
      logic [11:0] f, e;
      logic [7:0] d;
      int n, p;
      begin
         for (int k = 0; k < 6; k++) begin
            wr(`ADDR_LINE_FORMAT, line_format_ctrl[k]);
            n = 5 + int'(line_format_ctrl[k][1:0]);
            p = int'(line_format_ctrl[k][3]);
            d = 8'hb5 & ((8'h01 << n) - 8'h01);
            e = 12'hffe;
            for (int i = 0; i < n; i++) e[i + 1] = d[i];
            if (p != 0)
               e[n + 1] = line_format_ctrl[k][5] ? ~line_format_ctrl[k][4] : (^d ^ ~line_format_ctrl[k][4]);
            fork
               i_far.recv(n + p + 2, f);
               wr(`ADDR_TX_HOLD_WRITE, d);
            join
            `CHK(f, e)
         end
      end
   endtask : t_tx_formats

   task automatic t_stop();
      logic [7:0] line_format_ctrl [3] = '{8'h00, 8'h04, 8'h07};
      int stop [3] = '{16, 24, 32};
      int t, x;
      begin
         for (int k = 0; k < 3; k++) begin
            wr(`ADDR_LINE_FORMAT, line_format_ctrl[k]);
            wr(`ADDR_TX_HOLD_WRITE, 8'hff);
            wait_bit(`LS_HOLD_EMPTY);
            wr(`ADDR_TX_HOLD_WRITE, 8'hff);
            for (t = 0; t < 300 && serial_out_pin !== 1'b1; t++)
               @(negedge core_clk);
            for (t = 0; t < 600 && serial_out_pin === 1'b1; t++)
               @(negedge core_clk);
            x = 16 * (5 + int'(line_format_ctrl[k][1:0])) + stop[k];
            `CHK(t >= x && t <= x + 2, 1'b1)
            wait_bit(`LS_TX_EMPTY);
         end
      end
   endtask : t_stop

   task automatic t_rx();
      logic [7:0] d;
      begin
         wr(`ADDR_LINE_FORMAT, 8'h9a);
         i_far.send(8'hd3, 7, 1, ^(8'h53));
         rd(`ADDR_RX_FIFO_READ, d);
         `CHK(d, 8'h53)
         rd(`ADDR_LINE_STATUS, d);
         `CHK(d[3:2], 2'b00)
         wr(`ADDR_LINE_FORMAT, 8'h83);
         for (int i = 0; i < 33; i++) i_far.send(8'(i), 8, 0, 1'b0);
         rd(`ADDR_LINE_STATUS, d);
         `CHK(d[1:0], 2'b11)
         for (int i = 0; i < 32; i++) begin
            rd(`ADDR_RX_FIFO_READ, d);
            `CHK(d, 8'(i))
         end
         wr(`ADDR_FLOW_CTRL, 8'h20);
         i_far.send(8'h77, 8, 0, 1'b0);
         wr(`ADDR_LINE_FORMAT, 8'h03);
         rd(`ADDR_LINE_STATUS, d);
         `CHK(d[0], 1'b0)
         `CHK(rts_n, 1'b1)
         wr(`ADDR_LINE_FORMAT, 8'h83);
         `CHK(rts_n, 1'b0)
         i_far.send(8'h3c, 8, 0, 1'b0);
         rd(`ADDR_RX_FIFO_READ, d);
         `CHK(d, 8'h3c)
      end
   endtask : t_rx

   task automatic t_break();
      begin
         wr(`ADDR_LINE_FORMAT, 8'h43);
         for (int i = 0; i < 40; i++) begin
            @(negedge core_clk);
            `CHK(serial_out_pin, 1'b0)
         end
         wr(`ADDR_LINE_FORMAT, 8'h03);
         @(negedge core_clk);
         `CHK(serial_out_pin, 1'b1)
      end
   endtask : t_break

   // throttle on the second flow output, modem change and hold-empty irq
   task automatic t_misc();
      logic [7:0] d;
      begin
         wr(`ADDR_FLOW_CTRL, 8'h40);
         `CHK(dtr_n, 1'b1)
         wr(`ADDR_IRQ_MASK, 8'h04);
         `CHK(irq, 1'b0)
         cts_n = 1'b0;
         @(negedge core_clk);
         `CHK(irq, 1'b1)
         rd(`ADDR_MODEM_STATUS, d);
         `CHK(d, 8'h11)
         `CHK(irq, 1'b0)
         wr(`ADDR_IRQ_MASK, 8'h02);
         `CHK(irq, 1'b1)
      end
   endtask : t_misc

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         finish_test();
      end
   end

   initial begin
      rst = 1'b1;
      reg_req = '0;
      cts_n = 1'b1;
      dsr_n = 1'b1;
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      t_regs();
      t_tx_formats();
      t_stop();
      t_rx();
      t_break();
      t_misc();
      finish_test();
   end
endmodule : tb_uart_line_format_datapath

// ---- hdl/uart_line_format_datapath.sv ----
// serial line datapath: registers, transmitter, receiver and receive fifo
// What this block does
// - received bytes queue in a 32-byte fifo, popped by reading rx_fifo_read.
// - serial_in_pin is sampled and each character assembled into a byte.
// - transmit hold buffer accepts a byte while the previous one shifts out.
// - written byte moves into the shift register and leaves on serial_out_pin.
// - word_length codes 0..3 give 5, 6, 7 or 8 data bits both ways.
// - stop_bit_sel gives 1 stop, or 1.5 for 5-bit and 2 otherwise.
// - parity_enable adds a parity bit after the data, else none.
// - even_parity_sel picks odd parity when clear, even when set.
// - forced parity with even select clear sends constant 1.
// - break_force holds serial_out_pin low until cleared.
// - fifo_enable clear empties and disables the fifo; set accepts data.
// - fifo disabled drives the selected receiver flow control outputs high.
// - rx_fifo_read is read-only, tx_hold_write write-only, either master.
// - line and modem status can each raise the interrupt request.
// - irq_mask gates three interrupt sources individually.
`timescale 1ns/10ps
`include "uart_params.svh"

module uart_byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `FIFO_BYTES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clr,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fifo_st_t;
   fifo_st_t st_ff;
   fifo_st_t nxt_st;
   logic do_push;
   logic do_pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
      $error("fifo depth must be a power of two of at least 2");
   end

   assign in_ready = (st_ff.cnt != DEPTH[AW:0]);
   assign out_valid = (st_ff.cnt != '0);
   assign out_data = st_ff.mem[st_ff.rp];
   assign do_push = in_valid && in_ready;
   assign do_pop = out_valid && out_ready;

   always_comb begin
      nxt_st = st_ff;
      if (do_push) begin
         nxt_st.mem[st_ff.wp] = in_data;
         nxt_st.wp = st_ff.wp + 1'b1;
      end
      if (do_pop) begin
         nxt_st.rp = st_ff.rp + 1'b1;
      end
      unique case ({do_push, do_pop})
         2'b10: nxt_st.cnt = st_ff.cnt + 1'b1;
         2'b01: nxt_st.cnt = st_ff.cnt - 1'b1;
         default: nxt_st.cnt = st_ff.cnt;
      endcase
      if (clr) begin
         nxt_st.wp = '0;
         nxt_st.rp = '0;
         nxt_st.cnt = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule : uart_byte_fifo

module uart_line_format_datapath #(
   parameter int RX_DEPTH = `FIFO_BYTES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire uart_pkg::reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic rts_n,
   output logic dtr_n,
   input wire logic cts_n,
   input wire logic dsr_n,
   output logic irq
);
   typedef struct packed {
      uart_pkg::line_fmt_t fmt;
      logic [7:0] flow;
      logic [7:0] modem;
      logic [7:0] div_lo;
      logic [7:0] div_hi;
      logic [7:0] resume_chr;
      logic [7:0] pause_chr;
      logic [7:0] mask;
      logic [7:0] rdata;
      logic [15:0] baud_cnt;
      logic tick;
      uart_pkg::ser_state_t tx_st;
      logic [5:0] tx_tk;
      logic [3:0] tx_bit;
      logic [7:0] tx_sh;
      logic tx_par;
      logic [7:0] hold;
      logic hold_full;
      uart_pkg::ser_state_t rx_st;
      logic [5:0] rx_tk;
      logic [3:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_par;
      logic rx_push;
      logic [7:0] rx_byte;
      logic ovr;
      logic perr;
      logic ferr;
      logic brk_det;
      logic ms_delta;
      logic [1:0] ms_last;
      logic out_low;
      logic irq;
   } core_st_t;

   core_st_t st_ff;
   core_st_t nxt_st;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic fifo_pop;
   logic [3:0] nbits;
   logic [5:0] stop_ticks;
   logic [7:0] rx_aligned;
   logic rx_expect_par;
   logic ls_err;
   logic [7:0] line_status;
   logic [7:0] modem_status;

   if (RX_DEPTH < 2) begin : g_bad_depth
      $error("receive fifo depth too small");
   end

   function automatic logic parity_of(input logic [7:0] d,
                                      input uart_pkg::line_fmt_t f);
      logic [3:0] n;
      logic x;
      n = 4'(f.word_length) + `DATA_BITS_MIN;
      x = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < n) begin
            x = x ^ d[i];
         end
      end
      if (f.forced_parity) begin
         parity_of = !f.even_parity_sel;
      end else begin
         parity_of = f.even_parity_sel ? x : !x;
      end
   endfunction : parity_of

   // receive store; disabled fifo is held empty
   uart_byte_fifo #(
      .WIDTH(8),
      .DEPTH(RX_DEPTH)
   ) u_rx_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .clr(!st_ff.fmt.fifo_enable),
      .in_valid(st_ff.rx_push && st_ff.fmt.fifo_enable),
      .in_data(st_ff.rx_byte),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(fifo_pop)
   );

   assign fifo_pop = reg_req.rd && reg_req.addr == `ADDR_RX_FIFO_READ;
   assign nbits = 4'(st_ff.fmt.word_length) + `DATA_BITS_MIN;
   assign stop_ticks = !st_ff.fmt.stop_bit_sel ? `TICKS_PER_BIT :
      (st_ff.fmt.word_length == 2'h0 ? `TICKS_STOP_1_5 :
       `TICKS_STOP_2);
   assign rx_aligned = st_ff.rx_sh >> (`BYTE_BITS - nbits);
   assign rx_expect_par = parity_of(rx_aligned, st_ff.fmt);
   assign ls_err = st_ff.ovr || st_ff.perr || st_ff.ferr || st_ff.brk_det;

   always_comb begin
      line_status = '0;
      line_status[`LS_DATA_READY] = fifo_out_valid;
      line_status[`LS_OVERRUN] = st_ff.ovr;
      line_status[`LS_PARITY_ERR] = st_ff.perr;
      line_status[`LS_FRAMING_ERR] = st_ff.ferr;
      line_status[`LS_BREAK] = st_ff.brk_det;
      line_status[`LS_HOLD_EMPTY] = !st_ff.hold_full;
      line_status[`LS_TX_EMPTY] = !st_ff.hold_full &&
         st_ff.tx_st == uart_pkg::SER_IDLE;
      modem_status = '0;
      modem_status[1:0] = st_ff.ms_last;
      modem_status[`MS_DELTA] = st_ff.ms_delta;
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_st.rx_push = 1'b0;
      // baud generator: one tick at sixteen times the bit rate
      nxt_st.tick = 1'b0;
      if (st_ff.baud_cnt == '0) begin
         nxt_st.tick = 1'b1;
         nxt_st.baud_cnt = {st_ff.div_hi, st_ff.div_lo} -
            ({st_ff.div_hi, st_ff.div_lo} != '0 ? 16'h0001 : 16'h0000);
      end else begin
         nxt_st.baud_cnt = st_ff.baud_cnt - 16'h0001;
      end
      // register reads and their side effects
      nxt_st.rdata = '0;
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            `ADDR_RX_FIFO_READ: nxt_st.rdata = fifo_out_data;
            `ADDR_LINE_FORMAT: nxt_st.rdata = st_ff.fmt;
            `ADDR_FLOW_CTRL: nxt_st.rdata = st_ff.flow;
            `ADDR_MODEM_CTRL: nxt_st.rdata = st_ff.modem;
            `ADDR_LINE_STATUS: begin
               nxt_st.rdata = line_status;
               nxt_st.ovr = 1'b0;
               nxt_st.perr = 1'b0;
               nxt_st.ferr = 1'b0;
               nxt_st.brk_det = 1'b0;
            end
            `ADDR_MODEM_STATUS: begin
               nxt_st.rdata = modem_status;
               nxt_st.ms_delta = 1'b0;
            end
            `ADDR_DIV_LOW: nxt_st.rdata = st_ff.div_lo;
            `ADDR_DIV_HIGH: nxt_st.rdata = st_ff.div_hi;
            `ADDR_RESUME_CHAR: nxt_st.rdata = st_ff.resume_chr;
            `ADDR_PAUSE_CHAR: nxt_st.rdata = st_ff.pause_chr;
            `ADDR_IRQ_MASK: nxt_st.rdata = st_ff.mask;
            default: nxt_st.rdata = '0;
         endcase
      end
      // transmitter: load shift register from the hold buffer
      unique case (st_ff.tx_st)
         uart_pkg::SER_IDLE: begin
            if (st_ff.hold_full) begin
               nxt_st.tx_sh = st_ff.hold;
               nxt_st.tx_par = parity_of(st_ff.hold, st_ff.fmt);
               nxt_st.hold_full = 1'b0;
               nxt_st.tx_tk = '0;
               nxt_st.tx_st = uart_pkg::SER_START;
            end
         end
         uart_pkg::SER_START: begin
            if (st_ff.tick) begin
               nxt_st.tx_tk = st_ff.tx_tk + 6'h01;
               if (st_ff.tx_tk == `TICKS_PER_BIT - 6'h01) begin
                  nxt_st.tx_tk = '0;
                  nxt_st.tx_bit = '0;
                  nxt_st.tx_st = uart_pkg::SER_DATA;
               end
            end
         end
         uart_pkg::SER_DATA: begin
            if (st_ff.tick) begin
               nxt_st.tx_tk = st_ff.tx_tk + 6'h01;
               if (st_ff.tx_tk == `TICKS_PER_BIT - 6'h01) begin
                  nxt_st.tx_tk = '0;
                  nxt_st.tx_sh = st_ff.tx_sh >> 1;
                  nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
                  if (st_ff.tx_bit == nbits - 4'h1) begin
                     nxt_st.tx_st = st_ff.fmt.parity_enable ?
                        uart_pkg::SER_PARITY : uart_pkg::SER_STOP;
                  end
               end
            end
         end
         uart_pkg::SER_PARITY: begin
            if (st_ff.tick) begin
               nxt_st.tx_tk = st_ff.tx_tk + 6'h01;
               if (st_ff.tx_tk == `TICKS_PER_BIT - 6'h01) begin
                  nxt_st.tx_tk = '0;
                  nxt_st.tx_st = uart_pkg::SER_STOP;
               end
            end
         end
         uart_pkg::SER_STOP: begin
            if (st_ff.tick) begin
               nxt_st.tx_tk = st_ff.tx_tk + 6'h01;
               if (st_ff.tx_tk == stop_ticks - 6'h01) begin
                  nxt_st.tx_tk = '0;
                  nxt_st.tx_st = uart_pkg::SER_IDLE;
               end
            end
         end
         default: nxt_st.tx_st = uart_pkg::SER_IDLE;
      endcase
      // register writes; a write to the hold buffer wins over its unload
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            `ADDR_TX_HOLD_WRITE: begin
               nxt_st.hold = reg_req.wdata;
               nxt_st.hold_full = 1'b1;
            end
            `ADDR_LINE_FORMAT: nxt_st.fmt = reg_req.wdata;
            `ADDR_FLOW_CTRL: nxt_st.flow = reg_req.wdata;
            `ADDR_MODEM_CTRL: nxt_st.modem = reg_req.wdata;
            `ADDR_DIV_LOW: nxt_st.div_lo = reg_req.wdata;
            `ADDR_DIV_HIGH: nxt_st.div_hi = reg_req.wdata;
            `ADDR_RESUME_CHAR: nxt_st.resume_chr = reg_req.wdata;
            `ADDR_PAUSE_CHAR: nxt_st.pause_chr = reg_req.wdata;
            `ADDR_IRQ_MASK: nxt_st.mask = reg_req.wdata;
            default: nxt_st.mask = nxt_st.mask;
         endcase
      end
      // receiver: sample mid-bit on the oversampling tick
      unique case (st_ff.rx_st)
         uart_pkg::SER_IDLE: begin
            if (!serial_in_pin) begin
               nxt_st.rx_tk = '0;
               nxt_st.rx_st = uart_pkg::SER_START;
            end
         end
         uart_pkg::SER_START: begin
            if (st_ff.tick) begin
               nxt_st.rx_tk = st_ff.rx_tk + 6'h01;
               if (st_ff.rx_tk == `TICKS_HALF_BIT - 6'h01) begin
                  nxt_st.rx_tk = '0;
                  nxt_st.rx_bit = '0;
                  nxt_st.rx_st = serial_in_pin ? uart_pkg::SER_IDLE :
                     uart_pkg::SER_DATA;
               end
            end
         end
         uart_pkg::SER_DATA: begin
            if (st_ff.tick) begin
               nxt_st.rx_tk = st_ff.rx_tk + 6'h01;
               if (st_ff.rx_tk == `TICKS_PER_BIT - 6'h01) begin
                  nxt_st.rx_tk = '0;
                  nxt_st.rx_sh = {serial_in_pin, st_ff.rx_sh[7:1]};
                  nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
                  if (st_ff.rx_bit == nbits - 4'h1) begin
                     nxt_st.rx_st = st_ff.fmt.parity_enable ?
                        uart_pkg::SER_PARITY : uart_pkg::SER_STOP;
                  end
               end
            end
         end
         uart_pkg::SER_PARITY: begin
            if (st_ff.tick) begin
               nxt_st.rx_tk = st_ff.rx_tk + 6'h01;
               if (st_ff.rx_tk == `TICKS_PER_BIT - 6'h01) begin
                  nxt_st.rx_tk = '0;
                  nxt_st.rx_par = serial_in_pin;
                  nxt_st.rx_st = uart_pkg::SER_STOP;
               end
            end
         end
         uart_pkg::SER_STOP: begin
            if (st_ff.tick) begin
               nxt_st.rx_tk = st_ff.rx_tk + 6'h01;
               if (st_ff.rx_tk == `TICKS_PER_BIT - 6'h01) begin
                  nxt_st.rx_tk = '0;
                  nxt_st.rx_st = uart_pkg::SER_IDLE;
                  nxt_st.rx_byte = rx_aligned;
                  nxt_st.rx_push = 1'b1;
                  if (!serial_in_pin) begin
                     nxt_st.ferr = 1'b1;
                  end
                  if (!serial_in_pin && rx_aligned == '0) begin
                     nxt_st.brk_det = 1'b1;
                  end
                  if (st_ff.fmt.parity_enable &&
                      st_ff.rx_par != rx_expect_par) begin
                     nxt_st.perr = 1'b1;
                  end
               end
            end
         end
         default: nxt_st.rx_st = uart_pkg::SER_IDLE;
      endcase
      if (st_ff.rx_push && st_ff.fmt.fifo_enable && !fifo_in_ready) begin
         nxt_st.ovr = 1'b1;
      end
      // modem inputs: change is sticky until the status is read
      nxt_st.ms_last = {!dsr_n, !cts_n};
      if (nxt_st.ms_last != st_ff.ms_last) begin
         nxt_st.ms_delta = 1'b1;
      end
      // serial output follows the next transmit state
      unique case (nxt_st.tx_st)
         uart_pkg::SER_START: nxt_st.out_low = 1'b1;
         uart_pkg::SER_DATA: nxt_st.out_low = !nxt_st.tx_sh[0];
         uart_pkg::SER_PARITY: nxt_st.out_low = !nxt_st.tx_par;
         default: nxt_st.out_low = 1'b0;
      endcase
      if (nxt_st.fmt.break_force) begin
         nxt_st.out_low = 1'b1;
      end
      nxt_st.irq = |(nxt_st.mask[2:0] & {nxt_st.ms_delta,
         !nxt_st.hold_full, ls_err || fifo_out_valid});
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata = st_ff.rdata;
   assign serial_out_pin = !st_ff.out_low;
   assign irq = st_ff.irq;
   // receiver throttle while the fifo is off
   assign rts_n = !st_ff.fmt.fifo_enable && st_ff.flow[`FC_RTS];
   assign dtr_n = !st_ff.fmt.fifo_enable && st_ff.flow[`FC_DTR];

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   a_fifo_pop_data: assert property (
      fifo_pop && fifo_out_valid |=> reg_rdata == $past(fifo_out_data))
      else $error("rx fifo read returned wrong byte");
   a_rx_push_store: assert property (
      st_ff.rx_push && st_ff.fmt.fifo_enable && fifo_in_ready && !fifo_pop
      |=> fifo_out_valid)
      else $error("received byte not stored");
   a_hold_unload: assert property (
      st_ff.tx_st == uart_pkg::SER_IDLE && st_ff.hold_full &&
      !(reg_req.wr && reg_req.addr == `ADDR_TX_HOLD_WRITE)
      |=> !st_ff.hold_full && st_ff.tx_st == uart_pkg::SER_START)
      else $error("hold buffer not moved to shift register");
   a_tx_start_low: assert property (
      $rose(st_ff.tx_st == uart_pkg::SER_START) |-> !serial_out_pin)
      else $error("start bit not low");
   a_break_low: assert property (
      st_ff.fmt.break_force |-> !serial_out_pin)
      else $error("break did not hold output low");
   a_forced_par: assert property (
      st_ff.tx_st == uart_pkg::SER_PARITY && st_ff.fmt.forced_parity &&
      !st_ff.fmt.break_force && $stable(st_ff.fmt)
      |-> serial_out_pin == !st_ff.fmt.even_parity_sel)
      else $error("forced parity level wrong");
   a_no_par_state: assert property (
      !st_ff.fmt.parity_enable && $stable(st_ff.fmt) &&
      $past(st_ff.tx_st) == uart_pkg::SER_DATA
      |-> st_ff.tx_st != uart_pkg::SER_PARITY)
      else $error("parity sent while disabled");
   a_data_count: assert property (
      $rose(st_ff.tx_st == uart_pkg::SER_STOP ||
            st_ff.tx_st == uart_pkg::SER_PARITY) && $stable(st_ff.fmt)
      |-> st_ff.tx_bit == nbits)
      else $error("wrong number of data bits");
   a_fifo_flush: assert property (
      !st_ff.fmt.fifo_enable ##1 !st_ff.fmt.fifo_enable |-> !fifo_out_valid)
      else $error("disabled fifo not empty");
   a_stop_high: assert property (
      st_ff.tx_st == uart_pkg::SER_STOP && !st_ff.fmt.break_force
      |-> serial_out_pin)
      else $error("stop bit not high");
endmodule : uart_line_format_datapath

// ---- hdl/uart_params.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef UART_PARAMS_SVH
`define UART_PARAMS_SVH
`define ADDR_RX_FIFO_READ 16'hffa0
`define ADDR_TX_HOLD_WRITE 16'hffa1
`define ADDR_LINE_FORMAT 16'hffa2
`define ADDR_FLOW_CTRL 16'hffa3
`define ADDR_MODEM_CTRL 16'hffa4
`define ADDR_LINE_STATUS 16'hffa5
`define ADDR_MODEM_STATUS 16'hffa6
`define ADDR_DIV_LOW 16'hffa7
`define ADDR_DIV_HIGH 16'hffa8
`define ADDR_RESUME_CHAR 16'hffa9
`define ADDR_PAUSE_CHAR 16'hffaa
`define ADDR_IRQ_MASK 16'hffab
`define REG_RESET 8'h00
`define FC_RTS 5
`define FC_DTR 6
`define LS_DATA_READY 0
`define LS_OVERRUN 1
`define LS_PARITY_ERR 2
`define LS_FRAMING_ERR 3
`define LS_BREAK 4
`define LS_HOLD_EMPTY 5
`define LS_TX_EMPTY 6
`define MS_DELTA 4
`define DATA_BITS_MIN 4'h5
`define BYTE_BITS 4'h8
`define TICKS_PER_BIT 6'h10
`define TICKS_HALF_BIT 6'h08
`define TICKS_STOP_1_5 6'h18
`define TICKS_STOP_2 6'h20
`define FIFO_BYTES 32
`endif

// ---- hdl/uart_pkg.sv ----
// types shared by the serial line datapath
package uart_pkg;
   typedef enum logic [2:0] {
      SER_IDLE = 3'h0,
      SER_START = 3'h1,
      SER_DATA = 3'h3,
      SER_PARITY = 3'h2,
      SER_STOP = 3'h6
   } ser_state_t;

   typedef struct packed {
      logic fifo_enable;
      logic break_force;
      logic forced_parity;
      logic even_parity_sel;
      logic parity_enable;
      logic stop_bit_sel;
      logic [1:0] word_length;
   } line_fmt_t;

   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } reg_req_t;
endpackage : uart_pkg
